// file: hw/spc_blank_timer.sv
// Overcurrent blanking timer started at each PWM on-period
`timescale 1ns/100ps
`default_nettype none
module spc_blank_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic pwm_on,
  output logic blanking
);
  import spc_pkg::*;

  logic pwm_on_reg;
  logic active_reg;
  logic active_next;
  logic [BLANK_CNT_W-1:0] cnt_reg;
  logic [BLANK_CNT_W-1:0] cnt_next;
  wire logic on_rise = pwm_on & ~pwm_on_reg;
  wire logic at_end = (cnt_reg == BLANK_LAST);

  // ************************************************************
  // Blank window
  // ************************************************************
  // Counter holds while not running so a stopped clock keeps its place
  assign active_next = !run ? active_reg : (on_rise ? 1'b1 : (at_end ? 1'b0 : active_reg));
  assign cnt_next = !run ? cnt_reg :
                    (on_rise ? '0 : (active_reg && !at_end ? cnt_reg + 1'b1 : cnt_reg));
  assign blanking = on_rise | active_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_on_reg <= 1'b0;
      active_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      pwm_on_reg <= run ? pwm_on : pwm_on_reg;
      active_reg <= active_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// file: hw/spc_phase_ctrl.sv
// Phase input control with interlock, enable hold and fault latch
`timescale 1ns/100ps
`default_nettype none
module spc_phase_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic system_rst_n,
  input wire logic enable,
  input wire spc_pkg::spc_phase_t phase_in_n,
  input wire spc_pkg::spc_sense_t sense,
  input wire logic pwm_on,
  output spc_pkg::spc_phase_t winding_out,
  output logic fault_out,
  output logic fault_oe
);
  import spc_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  spc_state_t state_reg;
  spc_state_t state_next;
  spc_phase_t exc_reg;
  spc_phase_t exc_next;
  spc_phase_t drive_reg;
  spc_phase_t drive_next;
  logic fault_reg;
  logic fault_next;
  logic blanking;

  // ************************************************************
  // Input decode
  // ************************************************************
  wire spc_phase_t req = ~phase_in_n;
  wire logic a_clash = req.a & req.a_bar;
  wire logic b_clash = req.b & req.b_bar;
  spc_phase_t safe_req;
  assign safe_req.a = req.a & ~a_clash;
  assign safe_req.a_bar = req.a_bar & ~a_clash;
  assign safe_req.b = req.b & ~b_clash;
  assign safe_req.b_bar = req.b_bar & ~b_clash;

  // Internal clock stops when enable is low, so only the reset sequencing and the output gating still act then
  wire logic run = enable;
  wire logic oc_hit = sense.overcurrent & ~blanking;
  wire logic detect = oc_hit | sense.overheat;

  spc_blank_timer u_blank (
    .clk(clk),
    .rst(rst),
    .run(run),
    .pwm_on(pwm_on),
    .blanking(blanking)
  );

  // ************************************************************
  // Sequencing
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    exc_next = exc_reg;
    fault_next = fault_reg;
    unique case (state_reg)
      ST_RESET: begin
        exc_next = spc_phase_t'(EXC_INIT);
        fault_next = FAULT_RST;
        if (system_rst_n) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (run) begin
          exc_next = safe_req;
          if (detect) begin
            fault_next = 1'b1;
            state_next = ST_FAULT;
          end
        end
      end
      ST_FAULT: begin
        fault_next = 1'b1;
      end
    endcase
    if (!system_rst_n) begin
      state_next = ST_RESET;
      // A held reset level drops a latched fault at once, not one edge late
      fault_next = FAULT_RST;
    end
  end

  // Outputs follow the held excitation only while running and enabled
  assign drive_next = (state_next == ST_RUN && enable) ? exc_next : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RESET;
      exc_reg <= spc_phase_t'(EXC_INIT);
      drive_reg <= '0;
      fault_reg <= FAULT_RST;
    end else begin
      state_reg <= state_next;
      exc_reg <= exc_next;
      drive_reg <= drive_next;
      fault_reg <= fault_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign winding_out = drive_reg;
  // Open drain: only ever drives low
  assign fault_out = 1'b0;
  assign fault_oe = fault_reg;
endmodule
`default_nettype wire

// file: inc/spc_pkg.sv
// Package for the stepper phase input control block
package spc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam real BLANK_TIME_US = 5.5;
  // Longest time rounds down; at least one cycle
  localparam int BLANK_CYCLES_RAW = int'(BLANK_TIME_US * 1000.0) / CLK_PERIOD_NS;
  localparam int BLANK_CYCLES = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;
  localparam int BLANK_CNT_W = 10;
  localparam logic [BLANK_CNT_W-1:0] BLANK_LAST = BLANK_CNT_W'(BLANK_CYCLES - 1);

  // ************************************************************
  // Reset values
  // ************************************************************
  // Initial excitation: A and BB on
  localparam logic [3:0] EXC_INIT = 4'h9;
  localparam logic FAULT_RST = 1'b0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic a;
    logic a_bar;
    logic b;
    logic b_bar;
  } spc_phase_t;

  typedef struct packed {
    logic overcurrent;
    logic overheat;
  } spc_sense_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_RUN = 3'h2,
    ST_FAULT = 3'h4
  } spc_state_t;

endpackage

// file: verification/spc_ctl_model.sv
// Controller model that pulses the system reset input
`timescale 1ns/100ps
`default_nettype none
module spc_ctl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pulse,
  output logic system_rst_n
);
  logic [1:0] cnt_reg;
  // Low for three cycles, so a sluggish reset sampler still sees it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 2'h0;
    else if (pulse) cnt_reg <= 2'h3;
    else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
  end
  assign system_rst_n = (cnt_reg == 2'h0);
endmodule
`default_nettype wire

// file: verification/spc_monitor.sv
// Port checker for the phase input control block
`timescale 1ns/100ps
`default_nettype none
module spc_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic system_rst_n,
  input wire logic enable,
  input wire spc_pkg::spc_phase_t phase_in_n,
  input wire spc_pkg::spc_sense_t sense,
  input wire spc_pkg::spc_phase_t winding_out,
  input wire logic fault_oe
);
  import spc_pkg::*;
  wire [3:0] p = phase_in_n;
  wire [3:0] dec = ~p & {p[2], p[3], p[0], p[1]};
  wire run = enable && system_rst_n && sense == 2'h0 && !fault_oe;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_clear;
    !system_rst_n ##1 system_rst_n;
  endsequence
  a_pair_excl: assert property (
    !(winding_out.a && winding_out.a_bar) && !(winding_out.b && winding_out.b_bar))
    else $error("pair both on");
  a_phase_dec: assert property (
    run && $past(system_rst_n) && !$past(rst) |=> winding_out == $past(dec))
    else $error("bad decode");
  a_init_exc: assert property (
    s_clear ##0 enable |=> winding_out == 4'h9) else $error("no initial excitation");
  a_por_exc: assert property (
    $past(rst) && system_rst_n && enable |=> winding_out == 4'h9)
    else $error("no initial excitation after power-on");
  a_enable_off: assert property (
    !enable |=> winding_out == 4'h0) else $error("on while disabled");
  a_reset_off: assert property (
    !system_rst_n |=> winding_out == 4'h0 && !fault_oe) else $error("not in reset");
  a_fault_off: assert property (
    fault_oe |-> winding_out == 4'h0) else $error("on during fault");
  a_fault_latch: assert property (
    fault_oe && system_rst_n |=> fault_oe) else $error("fault dropped");
  a_heat_trip: assert property (
    enable && system_rst_n && $past(system_rst_n) && sense.overheat |-> ##[1:2] fault_oe)
    else $error("no overheat fault");
  a_fault_clear: assert property (
    s_clear |-> !fault_oe) else $error("fault kept");
endmodule
bind spc_phase_ctrl spc_monitor u_mon (.clk(clk), .rst(rst), .system_rst_n(system_rst_n),
  .enable(enable), .phase_in_n(phase_in_n), .sense(sense), .winding_out(winding_out),
  .fault_oe(fault_oe));
`default_nettype wire

// file: verification/test_spc_phase_ctrl.sv
// Self-checking bench for the phase input control block
`timescale 1ns/100ps
`default_nettype none
module test_spc_phase_ctrl;
  import spc_pkg::*;
  logic clk = 0, rst = 1, enable = 0, pwm_on = 0, clr = 0;
  logic [3:0] pin = 4'hF;
  logic [1:0] sns = 2'h0;
  logic [31:0] seed = 32'h6931;
  int n_errors = 0, num_checks = 0;
  wire logic rstn, fault_out, fault_oe;
  spc_phase_t wout;
  spc_ctl_model ctl (.clk(clk), .rst(rst), .pulse(clr), .system_rst_n(rstn));
  spc_phase_ctrl DUT (.clk(clk), .rst(rst), .system_rst_n(rstn), .enable(enable),
    .phase_in_n(pin), .sense(sns), .pwm_on(pwm_on), .winding_out(wout),
    .fault_out(fault_out), .fault_oe(fault_oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [3:0] dec(input logic [3:0] p, input logic en);
    return en ? ~p & {p[2], p[3], p[0], p[1]} : 4'h0;
  endfunction
  task automatic chk(input logic [3:0] exp, input logic f);
    num_checks++;
    if ({wout, fault_oe, fault_out} !== {exp, f, 1'b0}) begin
      n_errors++;
      $display("wrong value at %0t: windings %h fault %b", $time, wout, fault_oe);
    end
  endtask
  task automatic step(input logic [3:0] p, input logic en, input logic [1:0] s);
    pin = p;
    enable = en;
    sns = s;
    @(negedge clk);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    // First edge out of reset loads the A and BB excitation, not the inputs
    step(4'hF, 1'b1, 2'h0);
    chk(4'h9, 1'b0);
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      step(seed[3:0], seed[7:5] != 3'h0, 2'h0);
      chk(dec(pin, enable), 1'b0);
    end
    // Overcurrent inside the blanking span must not trip
    pwm_on = 1;
    repeat (10) step(4'h6, 1'b1, 2'h2);
    chk(4'h9, 1'b0);
    repeat (560) step(4'h6, 1'b1, 2'h2);
    chk(4'h0, 1'b1);
    step(4'h5, 1'b0, 2'h0);
    step(4'h5, 1'b1, 2'h0);
    chk(4'h0, 1'b1);
    clr = 1;
    @(negedge clk);
    clr = 0;
    repeat (4) step(4'h5, 1'b1, 2'h0);
    chk(4'h9, 1'b0);
    step(4'h5, 1'b1, 2'h0);
    chk(dec(4'h5, 1'b1), 1'b0);
    step(4'h5, 1'b1, 2'h1);
    chk(4'h0, 1'b1);
    print_verdict;
  end
endmodule
`default_nettype wire
